/* File: rtl/mfb_top.sv */
// MAC frame path: host port, packet FIFOs, MAC working buffers, MII and management bus
`timescale 1ns/10ps
`include "mfb_regs.svh"

module mfb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1, s2, s3;
  // A change counts only once two stages agree
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++)
        if (s2[i] == s3[i]) q[i] <= s3[i];
    end
endmodule

module mfb_fifo #(
  parameter int W = 33,
  parameter int D = 256
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic      [W-1:0]         out_data,
  input  wire logic [$clog2(D):0]   limit,
  output logic      [$clog2(D):0]   level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp, rp;
  logic          push, pop;
  assign in_ready  = (level < limit) && (level < (AW+1)'(D));
  assign out_valid = level != '0;
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_ff @(posedge clk)
    if (push) mem[wp] <= in_data;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wp    <= '0;
      rp    <= '0;
      level <= '0;
    end
    else
    begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
endmodule

module mfb_top (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  // Host SRAM-style port
  input  wire logic                 CS_N,
  input  wire logic                 RD_N,
  input  wire logic                 WR_N,
  input  wire logic                 FIFO_SEL,
  input  wire logic [7:1]           ADDR,
  input  wire logic [15:0]          DATA_I,
  output logic      [15:0]          DATA_O,
  output logic                      DATA_OE,
  // Internal PHY MII
  input  wire logic                 INT_TX_CLK,
  input  wire logic                 INT_RX_CLK,
  output mfb_pkg::mfb_mii_tx_t      INT_TX,
  input  wire mfb_pkg::mfb_mii_rx_t INT_RX,
  // External PHY MII
  input  wire logic                 EXT_TX_CLK,
  input  wire logic                 EXT_RX_CLK,
  output mfb_pkg::mfb_mii_tx_t      EXT_TX,
  input  wire mfb_pkg::mfb_mii_rx_t EXT_RX,
  // Management serial bus
  output logic                      MDC,
  input  wire logic                 MDIO_I,
  output logic                      MDIO_O,
  output logic                      MDIO_OE
);
  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  logic       rst_n, rst_m;
  logic [31:0] ctrl, fifo_cfg;
  logic        ext;
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end

  logic [26:0] hsync;
  logic        cs_n, rd_n, wr_n, fsel;
  logic [7:1]  addr;
  logic [15:0] din;
  // Strobes enter inverted so the cleared synchroniser reads as idle, no false access after reset
  mfb_sync #(.W(27)) u_hsync (.clk(CLK), .rst_n(rst_n), .d({~CS_N, ~RD_N, ~WR_N, FIFO_SEL, ADDR, DATA_I}), .q(hsync));
  assign {cs_n, rd_n, wr_n, fsel, addr, din} = {~hsync[26:24], hsync[23:0]};

  assign ext = ctrl[`MFB_CTRL_EXT_PHY];
  mfb_pkg::mfb_mii_rx_t rx_pin;
  logic                 rxc, txc, mdio_in;
  mfb_sync #(.W(9)) u_lsync (.clk(CLK), .rst_n(rst_n),
    .d({ext ? EXT_RX_CLK : INT_RX_CLK, ext ? EXT_TX_CLK : INT_TX_CLK, ext ? EXT_RX : INT_RX, MDIO_I}),
    .q({rxc, txc, rx_pin, mdio_in}));

  // ----------------------------------------
  // Host access decode
  // ----------------------------------------
  logic        rd_act, wr_act, rd_prev, wr_prev, rd_start, wr_end;
  logic [15:0] wdat, stage, tx_half;
  logic        tx_hsel, rx_hsel, big;
  logic [7:0]  baddr;
  assign rd_act   = ~cs_n & ~rd_n;
  assign wr_act   = ~cs_n & ~wr_n;
  assign rd_start = rd_act & ~rd_prev;
  assign wr_end   = ~wr_act & wr_prev;
  assign big      = ctrl[`MFB_CTRL_BIG_END];
  assign baddr    = {addr[7:2], 2'b00};
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      wdat    <= '0;
      DATA_OE <= 1'b0;
    end
    else
    begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
      DATA_OE <= rd_act;
      if (wr_act) wdat <= din;
    end

  // ----------------------------------------
  // Packet FIFOs and MAC working buffers
  // ----------------------------------------
  logic        txf_iv, txf_ir, txf_ov, mtx_ir, mtx_ov, mtx_or;
  logic        mrx_iv, mrx_ir, mrx_ov, rxf_ir, rxf_ov, rxf_or;
  logic [32:0] txf_id, txf_od, mtx_od, mrx_id, mrx_od, rxf_od;
  logic [8:0]  txf_lvl, rxf_lvl;
  // Host side, size set by software
  mfb_fifo #(.W(33), .D(`MFB_FIFO_DEPTH)) u_txf (.clk(CLK), .rst_n(rst_n), .in_valid(txf_iv), .in_ready(txf_ir),
    .in_data(txf_id), .out_valid(txf_ov), .out_ready(mtx_ir), .out_data(txf_od), .limit(fifo_cfg[8:0]),
    .level(txf_lvl));
  // MAC working buffers have no host path at all
  mfb_fifo #(.W(33), .D(`MFB_MTX_DEPTH)) u_mtx (.clk(CLK), .rst_n(rst_n), .in_valid(txf_ov), .in_ready(mtx_ir),
    .in_data(txf_od), .out_valid(mtx_ov), .out_ready(mtx_or), .out_data(mtx_od), .limit(10'(`MFB_MTX_DEPTH)),
    .level());
  mfb_fifo #(.W(33), .D(`MFB_MRX_DEPTH)) u_mrx (.clk(CLK), .rst_n(rst_n), .in_valid(mrx_iv), .in_ready(mrx_ir),
    .in_data(mrx_id), .out_valid(mrx_ov), .out_ready(rxf_ir), .out_data(mrx_od), .limit(6'(`MFB_MRX_DEPTH)),
    .level());
  mfb_fifo #(.W(33), .D(`MFB_FIFO_DEPTH)) u_rxf (.clk(CLK), .rst_n(rst_n), .in_valid(mrx_ov), .in_ready(rxf_ir),
    .in_data(mrx_od), .out_valid(rxf_ov), .out_ready(rxf_or), .out_data(rxf_od), .limit(fifo_cfg[24:16]),
    .level(rxf_lvl));

  // ----------------------------------------
  // Host data FIFO and register accesses
  // ----------------------------------------
  logic        fifo_wr, fifo_rd, csr_wr, csr_rd, mgmt_go, mgmt_busy;
  logic [31:0] wword, rword;
  logic [15:0] mgmt_data;
  assign fifo_wr = wr_end & fsel;
  assign fifo_rd = rd_start & fsel;
  assign csr_wr  = wr_end & ~fsel & addr[1];
  assign csr_rd  = rd_start & ~fsel;
  // Lower address half arrives first in either byte order
  assign wword   = big ? {stage, wdat} : {wdat, stage};
  assign txf_iv  = fifo_wr & tx_hsel;
  assign txf_id  = {ctrl[`MFB_CTRL_TX_LAST], big ? {tx_half, wdat} : {wdat, tx_half}};
  assign rxf_or  = fifo_rd & rx_hsel & rxf_ov;
  assign mgmt_go = csr_wr && baddr == `MFB_OFS_MGMT_CMD && !mgmt_busy;
  always_comb
  begin
    unique case (baddr)
      `MFB_OFS_CTRL:      rword = ctrl;
      `MFB_OFS_FIFO_CFG:  rword = fifo_cfg;
      // Head of an empty FIFO is stale memory, so its tag counts only while a word waits
      `MFB_OFS_STATUS:    rword = {rxf_ov & rxf_od[32], mgmt_busy, 5'h00, rxf_lvl, 7'h00, txf_lvl};
      `MFB_OFS_MGMT_DATA: rword = {16'h0000, mgmt_data};
      default:            rword = 32'h0000_0000;
    endcase
  end
  // Register bus shares the host port with both data paths and DATA_O with the receive path only
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      ctrl     <= `MFB_RST_CTRL;
      fifo_cfg <= `MFB_RST_FIFO_CFG;
      stage    <= '0;
      tx_half  <= '0;
      tx_hsel  <= 1'b0;
      rx_hsel  <= 1'b0;
      DATA_O   <= '0;
    end
    else
    begin
      if (wr_end & ~fsel & ~addr[1]) stage <= wdat;
      if (csr_wr && baddr == `MFB_OFS_CTRL) ctrl <= wword;
      else if (txf_iv && txf_ir) ctrl[`MFB_CTRL_TX_LAST] <= 1'b0;
      if (csr_wr && baddr == `MFB_OFS_FIFO_CFG) fifo_cfg <= wword & 32'h01ff_01ff;
      if (fifo_wr)
      begin
        tx_half <= wdat;
        tx_hsel <= ~tx_hsel;
      end
      if (csr_rd) DATA_O <= (addr[1] ^ big) ? rword[31:16] : rword[15:0];
      else if (fifo_rd)
      begin
        DATA_O <= rxf_ov ? ((rx_hsel ^ big) ? rxf_od[31:16] : rxf_od[15:0]) : 16'h0000;
        if (rxf_ov) rx_hsel <= ~rx_hsel;
      end
    end

  // ----------------------------------------
  // Transmitter, store-and-forward
  // ----------------------------------------
  mfb_pkg::mfb_tx_state_t tx_st;
  mfb_pkg::mfb_mii_tx_t   tx_q;
  logic [9:0]  frames;
  logic [31:0] tx_sh;
  logic [2:0]  tx_nib;
  logic        tx_tag, txc_prev, tx_rise, frame_in, frame_out;
  assign tx_rise   = txc & ~txc_prev;
  assign frame_in  = txf_ov & mtx_ir & txf_od[32];
  assign frame_out = tx_rise && tx_st == mfb_pkg::MFB_TX_SEND && tx_nib == 3'd7 && tx_tag;
  assign mtx_or    = tx_rise && mtx_ov && (tx_st == mfb_pkg::MFB_TX_IDLE ? ctrl[`MFB_CTRL_TX_EN] && frames != '0
                     : tx_nib == 3'd7 && !tx_tag);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      frames <= '0;
      txc_prev <= 1'b0;
    end
    else
    begin
      txc_prev <= txc;
      frames   <= frames + 10'(frame_in) - 10'(frame_out);
    end
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      tx_st  <= mfb_pkg::MFB_TX_IDLE;
      tx_q   <= '0;
      tx_sh  <= '0;
      tx_nib <= '0;
      tx_tag <= 1'b0;
    end
    else if (mtx_or)
    begin
      tx_st  <= mfb_pkg::MFB_TX_SEND;
      tx_q   <= '{en: 1'b1, d: mtx_od[3:0]};
      tx_sh  <= mtx_od[31:0];
      tx_tag <= mtx_od[32];
      tx_nib <= 3'd0;
    end
    else if (tx_rise && tx_st == mfb_pkg::MFB_TX_SEND)
    begin
      if (tx_nib == 3'd7)
      begin
        tx_st <= mfb_pkg::MFB_TX_IDLE;
        tx_q  <= '0;
      end
      else
      begin
        tx_nib <= tx_nib + 3'd1;
        tx_q.d <= tx_sh[4*(tx_nib+1) +: 4];
      end
    end
  assign INT_TX = ext ? '0 : tx_q;
  assign EXT_TX = ext ? tx_q : '0;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic [31:0] rx_sh;
  logic [2:0]  rx_nib;
  logic [15:0] rx_cnt;
  logic        rxc_prev, rx_rise, rx_in, rx_err, rx_ovf;
  assign rx_rise = rxc & ~rxc_prev;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      rxc_prev <= 1'b0;
      rx_sh    <= '0;
      rx_nib   <= '0;
      rx_cnt   <= '0;
      rx_in    <= 1'b0;
      rx_err   <= 1'b0;
      rx_ovf   <= 1'b0;
      mrx_iv   <= 1'b0;
      mrx_id   <= '0;
    end
    else
    begin
      rxc_prev <= rxc;
      mrx_iv   <= 1'b0;
      if (mrx_iv && !mrx_ir) rx_ovf <= 1'b1;
      if (rx_rise && rx_pin.dv && (rx_in || ctrl[`MFB_CTRL_RX_EN]))
      begin
        rx_in  <= 1'b1;
        rx_err <= rx_err | rx_pin.er;
        rx_sh  <= {rx_pin.d, rx_sh[31:4]};
        rx_nib <= rx_nib + 3'd1;
        if (rx_nib == 3'd7)
        begin
          mrx_iv <= 1'b1;
          mrx_id <= {1'b0, rx_pin.d, rx_sh[31:4]};
          rx_cnt <= rx_cnt + 16'd4;
        end
      end
      else if (rx_rise && rx_in)
      begin
        // Frame status follows its data on the same bus
        mrx_iv <= 1'b1;
        mrx_id <= {1'b1, rx_err, rx_ovf | (mrx_iv & ~mrx_ir), 14'h0000, rx_cnt};
        rx_in  <= 1'b0;
        rx_err <= 1'b0;
        rx_ovf <= 1'b0;
        rx_nib <= '0;
        rx_cnt <= '0;
      end
    end

  // ----------------------------------------
  // Management serial bus
  // ----------------------------------------
  logic [63:0] mg_sh;
  logic [5:0]  mg_bit;
  logic [1:0]  mg_div;
  logic        mg_wr;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      mgmt_busy <= 1'b0;
      mgmt_data <= '0;
      mg_sh     <= '0;
      mg_bit    <= '0;
      mg_div    <= '0;
      mg_wr     <= 1'b0;
      MDC       <= 1'b0;
      MDIO_O    <= 1'b0;
      MDIO_OE   <= 1'b0;
    end
    else if (mgmt_go)
    begin
      mgmt_busy <= 1'b1;
      mg_wr     <= wword[`MFB_MGMT_WRITE];
      mg_sh     <= {32'hffff_ffff, 2'b01, wword[`MFB_MGMT_WRITE] ? 2'b01 : 2'b10, wword[9:5], wword[4:0], 2'b10,
                    mgmt_data};
      mg_bit    <= '0;
      mg_div    <= '0;
      MDIO_O    <= 1'b1;
      MDIO_OE   <= 1'b1;
    end
    else
    begin
      if (csr_wr && baddr == `MFB_OFS_MGMT_DATA && !mgmt_busy) mgmt_data <= wword[15:0];
      if (mgmt_busy)
      begin
        mg_div <= (mg_div == 2'(`MFB_MDC_HALF_CYC - 1)) ? 2'd0 : mg_div + 2'd1;
        if (mg_div == 2'(`MFB_MDC_HALF_CYC - 1))
        begin
          MDC <= ~MDC;
          if (!MDC && !mg_wr && mg_bit >= 6'd48) mgmt_data <= {mgmt_data[14:0], mdio_in};
          if (MDC)
          begin
            mg_bit  <= mg_bit + 6'd1;
            mg_sh   <= {mg_sh[62:0], 1'b0};
            MDIO_O  <= mg_sh[62];
            // Reads hand the line to the PHY at turnaround
            MDIO_OE <= mg_wr || mg_bit < 6'd45;
            if (mg_bit == 6'd63)
            begin
              mgmt_busy <= 1'b0;
              MDIO_OE   <= 1'b0;
            end
          end
        end
      end
    end
endmodule

/* File: rtl/mfb_regs.svh */
// Offsets, field positions, reset values and timing counts of the MAC frame path
`ifndef MFB_REGS_SVH
`define MFB_REGS_SVH
// ----------------------------------------
// Control and status register byte offsets
// ----------------------------------------
`define MFB_OFS_CTRL      8'h00
`define MFB_OFS_FIFO_CFG  8'h04
`define MFB_OFS_STATUS    8'h08
`define MFB_OFS_MGMT_CMD  8'h0c
`define MFB_OFS_MGMT_DATA 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MFB_CTRL_TX_EN    0
`define MFB_CTRL_RX_EN    1
`define MFB_CTRL_BIG_END  2
`define MFB_CTRL_EXT_PHY  3
`define MFB_CTRL_TX_LAST  4
`define MFB_MGMT_WRITE    10
`define MFB_STAT_RX_TAG   31
`define MFB_STAT_MGMT_BSY 30
// ----------------------------------------
// Reset values and depths
// ----------------------------------------
`define MFB_RST_CTRL      32'h0000_0003
`define MFB_RST_FIFO_CFG  32'h0100_0100
`define MFB_FIFO_DEPTH    256
`define MFB_MTX_DEPTH     512
`define MFB_MRX_DEPTH     32
// ----------------------------------------
// Timing
// ----------------------------------------
`define MFB_CLK_NS        100
`define MFB_MDC_HALF_NS   200
`define MFB_MDC_HALF_CYC  ((`MFB_MDC_HALF_NS + `MFB_CLK_NS - 1) / `MFB_CLK_NS)
`endif

/* File: rtl/mfb_pkg.sv */
// Types shared by the MAC frame path
package mfb_pkg;
  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } mfb_mii_tx_t;
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mfb_mii_rx_t;
  typedef enum logic {MFB_TX_IDLE, MFB_TX_SEND} mfb_tx_state_t;
endpackage

/* File: tb/mfb_chk.sv */
// Port assertions for the MAC frame path, bound into its top module
`timescale 1ns/10ps
module mfb_chk (
  // Clock and reset
  input wire logic                 CLK,
  input wire logic                 NRST,
  // Host port
  input wire logic                 CS_N,
  input wire logic                 RD_N,
  input wire logic                 DATA_OE,
  // MII transmit
  input wire mfb_pkg::mfb_mii_tx_t INT_TX,
  input wire mfb_pkg::mfb_mii_tx_t EXT_TX,
  // Management bus
  input wire logic                 MDC,
  input wire logic                 MDIO_O,
  input wire logic                 MDIO_OE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // Strobes pass a synchroniser, so every answer lags by several cycles
  rd_answer_a: assert property ($fell(RD_N) && !CS_N |-> ##[3:6] DATA_OE)
    else $error("read data not driven in time");
  rd_cause_a: assert property ($rose(DATA_OE) |-> !$past(RD_N, 3) && !$past(CS_N, 3))
    else $error("data bus driven without a read");
  oe_hold_a: assert property (!RD_N && !CS_N && DATA_OE |=> DATA_OE)
    else $error("read data dropped during strobe");
  oe_release_a: assert property ($rose(RD_N) |-> ##[3:6] !DATA_OE)
    else $error("data bus not released");
  tx_excl_a: assert property (!(INT_TX.en && EXT_TX.en))
    else $error("both transmit ports active");
  int_nibble_a: assert property ($rose(INT_TX.en) |-> ##1 $stable(INT_TX)[*6])
    else $error("internal nibble shorter than a clock period");
  ext_nibble_a: assert property ($rose(EXT_TX.en) |-> ##1 $stable(EXT_TX)[*6])
    else $error("external nibble shorter than a clock period");
  mdc_period_a: assert property ($rose(MDC) |=> MDC ##1 !MDC)
    else $error("management clock high phase wrong");
  mdio_edge_a: assert property (MDIO_OE && $past(MDIO_OE) && $changed(MDIO_O) |-> !MDC)
    else $error("management data changed while clock high");
endmodule

bind mfb_top mfb_chk i_chk (.CLK, .NRST, .CS_N, .RD_N, .DATA_OE, .INT_TX, .EXT_TX, .MDC, .MDIO_O, .MDIO_OE);

/* File: tb/mfb_phy.sv */
// Behavioural PHY on one MII port: free clocks, frame source and nibble sink
`timescale 1ns/10ps
module mfb_phy #(
  parameter int PH = 37
) (
  // MII clocks
  output logic                      tx_clk,
  output logic                      rx_clk,
  // MII data
  input  wire mfb_pkg::mfb_mii_tx_t tx,
  output mfb_pkg::mfb_mii_rx_t      rx
);
  logic [31:0] sh;
  logic [31:0] got[$];
  logic [3:0]  nq[$];
  int          n = 0;
  // MII clocks run free, phase unrelated to the system clock
  initial
  begin
    tx_clk = 1'b0;
    #PH;
    forever #400 tx_clk = ~tx_clk;
  end
  initial
  begin
    rx_clk = 1'b0;
    rx     = '0;
    #(PH + 160);
    forever #400 rx_clk = ~rx_clk;
  end
  // Words arrive LS nibble first, eight nibbles each
  always @(posedge tx_clk)
    if (tx.en === 1'b1)
    begin
      sh = {tx.d, sh[31:4]};
      n  = n + 1;
      if (n == 8)
      begin
        got.push_back(sh);
        n = 0;
      end
    end
  // Idle data lines toggle so a stale nibble never looks valid
  always @(negedge rx_clk)
    if (nq.size() > 0)
    begin
      rx.dv <= 1'b1;
      rx.d  <= nq.pop_front();
    end
    else
    begin
      rx.dv <= 1'b0;
      rx.d  <= ~rx.d;
    end
  // Queues a frame of k words w, w+1, ...
  task automatic send(input logic [31:0] w, input int k);
    for (int i = 0; i < 8 * k; i++)
      nq.push_back(4'((w + i / 8) >> (4 * (i % 8))));
  endtask
endmodule

/* File: tb/tb.sv */
// Bench for the MAC frame path: host port scenarios against two PHY models
`timescale 1ns/10ps
module tb;
  logic                 clk, nrst, cs_n, rd_n, wr_n, fifo_sel, be, data_oe;
  logic                 itc, irc, etc, erc, mdc, mdio_o, mdio_oe, mdio_i;
  logic [7:1]           addr;
  logic [15:0]          data_i, data_o;
  logic [31:0]          v;
  logic [63:0]          mfr;
  mfb_pkg::mfb_mii_tx_t itx, etx;
  mfb_pkg::mfb_mii_rx_t irx, erx;
  int                   mismatches, n_checks;

  // Pull-up on the management data line
  assign mdio_i = mdio_oe ? mdio_o : 1'b1;
  always @(posedge mdc)
    if (mdio_oe)
      mfr <= {mfr[62:0], mdio_o};

  mfb_top i_dut (
    .CLK(clk), .NRST(nrst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .FIFO_SEL(fifo_sel), .ADDR(addr),
    .DATA_I(data_i), .DATA_O(data_o), .DATA_OE(data_oe), .INT_TX_CLK(itc), .INT_RX_CLK(irc),
    .INT_TX(itx), .INT_RX(irx), .EXT_TX_CLK(etc), .EXT_RX_CLK(erc), .EXT_TX(etx), .EXT_RX(erx),
    .MDC(mdc), .MDIO_I(mdio_i), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe)
  );
  mfb_phy #(.PH(37)) i_pi (.tx_clk(itc), .rx_clk(irc), .tx(itx), .rx(irx));
  mfb_phy #(.PH(291)) i_pe (.tx_clk(etc), .rx_clk(erc), .tx(etx), .rx(erx));

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One host access; strobes are synchronised, so each phase lasts six cycles
  task automatic acc(input logic w, input logic f, input logic [7:1] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge clk);
    fifo_sel = f;
    addr     = a;
    data_i   = d;
    cs_n     = 1'b0;
    wr_n     = !w;
    rd_n     = w;
    repeat (6) @(negedge clk);
    q = data_o;
    if (!w)
      chk(data_oe, 1'b1, "read data not driven");
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic rd32(input logic [7:0] o, output logic [31:0] r);
    logic [15:0] a, b;
    acc(1'b0, 1'b0, {o[7:2], 1'b0}, 16'h0, a);
    acc(1'b0, 1'b0, {o[7:2], 1'b1}, 16'h0, b);
    r = be ? {a, b} : {b, a};
  endtask
  task automatic wr32(input logic [7:0] o, input logic [31:0] w);
    logic [15:0] q;
    acc(1'b1, 1'b0, {o[7:2], 1'b0}, be ? w[31:16] : w[15:0], q);
    acc(1'b1, 1'b0, {o[7:2], 1'b1}, be ? w[15:0] : w[31:16], q);
  endtask
  // Upper address bits are set on purpose: they must not matter with FIFO select high
  task automatic fpush(input logic [31:0] w, input logic [7:1] a);
    logic [15:0] q;
    acc(1'b1, 1'b1, a, be ? w[31:16] : w[15:0], q);
    acc(1'b1, 1'b1, a, be ? w[15:0] : w[31:16], q);
  endtask
  task automatic fpop(output logic [31:0] r);
    logic [15:0] a, b;
    acc(1'b0, 1'b1, 7'h7c, 16'h0, a);
    acc(1'b0, 1'b1, 7'h54, 16'h0, b);
    r = be ? {a, b} : {b, a};
  endtask
  task wtx(input int k);
    for (int i = 0; i < 400 && i_pi.got.size() + i_pe.got.size() < k; i++)
      @(negedge clk);
    if (i_pi.got.size() + i_pe.got.size() < k)
    begin
      mismatches++;
      $display("BAD %0t transmit wait ran out", $time);
      end_sim();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs();
    rd32(8'h00, v);
    chk(v, 32'h0000_0003, "control reset value");
    rd32(8'h04, v);
    chk(v, 32'h0100_0100, "fifo size reset value");
    rd32(8'h08, v);
    chk(v, 32'h0, "status reset value");
    rd32(8'h20, v);
    chk(v, 32'h0, "unmapped read");
    wr32(8'h04, 32'hffff_ffff);
    rd32(8'h04, v);
    chk(v, 32'h01ff_01ff, "fifo size fields");
    wr32(8'h04, 32'h0100_0100);
  endtask
  task t_tx();
    fpush(32'h1234_5678, 7'h7c);
    repeat (100) @(negedge clk);
    chk(i_pi.got.size(), 0, "sent before frame complete");
    wr32(8'h00, 32'h13);
    fpush(32'h9abc_def0, 7'h40);
    wtx(2);
    repeat (20) @(negedge clk);
    chk(i_pi.got[0], 32'h1234_5678, "first frame word");
    chk(i_pi.got[1], 32'h9abc_def0, "last frame word");
    chk(itx.en, 1'b0, "enable after last word");
    i_pi.got.delete();
  endtask
  task t_rx();
    i_pi.send(32'hc0de_0001, 2);
    repeat (250) @(negedge clk);
    rd32(8'h08, v);
    chk(v[24:16], 32'd3, "receive fifo level");
    chk(v[31], 1'b0, "head is data");
    fpop(v);
    chk(v, 32'hc0de_0001, "rx word 0");
    fpop(v);
    chk(v, 32'hc0de_0002, "rx word 1");
    rd32(8'h08, v);
    chk(v[31], 1'b1, "head is status");
    fpop(v);
    chk(v, 32'h0000_0008, "rx status word");
    fpop(v);
    chk(v, 32'h0, "empty rx fifo read");
    wr32(8'h00, 32'h01);
    i_pi.send(32'h0bad_0bad, 1);
    repeat (120) @(negedge clk);
    rd32(8'h08, v);
    chk(v[24:16], 32'd0, "frame taken while receive disabled");
    wr32(8'h00, 32'h03);
  endtask
  task t_be();
    wr32(8'h00, 32'h07);
    be = 1'b1;
    rd32(8'h00, v);
    chk(v, 32'h07, "big endian control");
    wr32(8'h00, 32'h17);
    fpush(32'h5566_7788, 7'h02);
    wtx(1);
    chk(i_pi.got[0], 32'h5566_7788, "big endian word");
    wr32(8'h00, 32'h03);
    be = 1'b0;
    i_pi.got.delete();
  endtask
  task t_ext();
    wr32(8'h00, 32'h1b);
    fpush(32'ha1b2_c3d4, 7'h00);
    wtx(1);
    chk(i_pe.got[0], 32'ha1b2_c3d4, "external port word");
    chk(i_pi.got.size(), 0, "internal port idle");
    wr32(8'h00, 32'h03);
  endtask
  task t_mgmt();
    wr32(8'h10, 32'h0000_a5c3);
    wr32(8'h0c, 32'h0000_04b1);
    v = 32'hffff_ffff;
    for (int i = 0; i < 40 && v[30] !== 1'b0; i++)
      rd32(8'h08, v);
    chk(v[30], 1'b0, "management busy stuck");
    chk(mfr[63:32], 32'hffff_ffff, "management preamble");
    chk(mfr[31:0], {2'b01, 2'b01, 5'h05, 5'h11, 2'b10, 16'ha5c3}, "management frame");
    wr32(8'h0c, 32'h0000_00b1);
    v = 32'hffff_ffff;
    for (int i = 0; i < 40 && v[30] !== 1'b0; i++)
      rd32(8'h08, v);
    chk(v[30], 1'b0, "management read busy stuck");
    chk(mfr[45:14], 32'hffff_ffff, "management read preamble");
    chk(mfr[13:0], {2'b01, 2'b10, 5'h05, 5'h11}, "management read header");
    rd32(8'h10, v);
    chk(v, 32'h0000_ffff, "management read of idle line");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("BAD %0t run time limit", $time);
    end_sim();
  end
  initial
  begin
    {nrst, fifo_sel, be, addr, data_i} = '0;
    {cs_n, rd_n, wr_n} = 3'h7;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    t_regs();
    t_tx();
    t_rx();
    t_be();
    t_ext();
    t_mgmt();
    end_sim();
  end
endmodule
